// >>> test/ptpe_host_model.sv
/* Host model that picks taps for the encoder.
   Assumes the bench calls send from its main sequence. */
`timescale 1ns/1ps
`default_nettype none
module ptpe_host_model
(
   input  wire logic              clk,
   output logic                   tap_valid,
   output logic signed [7:0]      tap_pos
);
   initial tap_valid = 1'b0;
   initial tap_pos = 8'sh00;
   // One-cycle strobe, returns on the edge that takes it
   task send(input logic signed [7:0] t);
      @(posedge clk);
      tap_valid <= 1'b1;
      tap_pos   <= t;
      @(posedge clk);
      tap_valid <= 1'b0;
   endtask : send
endmodule : ptpe_host_model
`default_nettype wire

// >>> test/ptpe_tap_encoder_asserts.sv
/* Port checker for the tap encoder.
   Assumes it is bound to ptpe_tap_encoder and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module ptpe_asserts
(
   input wire logic              clk, resetn, power_good, tap_valid, wiper_update, recall_done,
   input wire logic [7:0]        stored_wiper, wiper_code,
   input wire logic signed [7:0] tap_pos
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // Request is taken only once recall has finished
   wire tk = tap_valid && recall_done;
   property p_seg0; tk && tap_pos inside {[0:24]} |=> wiper_code == $past(tap_pos); endproperty
   a_seg0: assert property (p_seg0) else $error("seg0 code wrong");
   property p_seg1; tk && tap_pos inside {[25:49]} |=> wiper_code == 8'h0051 - $past(tap_pos); endproperty
   a_seg1: assert property (p_seg1) else $error("seg1 code wrong");
   property p_seg2; tk && tap_pos inside {[50:74]} |=> wiper_code == 8'h000E + $past(tap_pos); endproperty
   a_seg2: assert property (p_seg2) else $error("seg2 code wrong");
   property p_seg3; tk && tap_pos inside {[75:99]} |=> wiper_code == 8'h00C3 - $past(tap_pos); endproperty
   a_seg3: assert property (p_seg3) else $error("seg3 code wrong");
   property p_neg; tk && tap_pos < 0 |=> wiper_code == 8'h0000; endproperty
   a_neg: assert property (p_neg) else $error("negative clamp wrong");
   property p_high; tk && tap_pos > 99 |=> wiper_code == 8'h0060; endproperty
   a_high: assert property (p_high) else $error("high clamp wrong");
   // The load and the rise of recall_done come from the same edge
   property p_recall; $rose(recall_done) |-> wiper_update && wiper_code == stored_wiper; endproperty
   a_recall: assert property (p_recall) else $error("recall load wrong");
   property p_answer; tk |=> wiper_update; endproperty
   a_answer: assert property (p_answer) else $error("no update after request");
   cover property (tk && tap_pos > 99);
   cover property ($rose(recall_done));
   cover property (tk ##1 tk);
endmodule : ptpe_asserts
`default_nettype wire

// >>> test/ptpe_tap_encoder_tb_top.sv
/* Bench for the tap encoder: recall, segment ends, clamps.
   Assumes a short recall count of 20 cycles. */
`timescale 1ns/1ps
`default_nettype none
module ptpe_tap_encoder_tb_top;
   logic clk = 1'b0, resetn = 1'b0, power_good = 1'b1, tap_valid, wiper_update, recall_done;
   logic [7:0] stored_wiper = 8'h002A, wiper_code;
   logic signed [7:0] tap_pos;
   int failures = 0, n_tests = 0;
   always #5 clk = ~clk;
   ptpe_host_model hm (.clk(clk), .tap_valid(tap_valid), .tap_pos(tap_pos));
   ptpe_tap_encoder #(.RECALL_CYC(20)) dut (.clk(clk), .resetn(resetn), .power_good(power_good),
      .stored_wiper(stored_wiper), .tap_valid(tap_valid), .tap_pos(tap_pos),
      .wiper_code(wiper_code), .wiper_update(wiper_update), .recall_done(recall_done));
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         failures++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   task end_sim;
      if (failures == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   // Request during recall wait is dropped, then recall loads the stored byte
   task t_recall;
      int n;
      hm.send(8'sd5);
      #1 check(wiper_code, 8'h0000);
      for (n = 0; n < 40 && recall_done !== 1'b1; n++) @(posedge clk);
      #1 check(wiper_code, stored_wiper);
      check(8'(n > 15), 8'h0001);
   endtask : t_recall
   // Segment ends and both clamps
   task t_map;
      logic signed [7:0] tp [10] = '{0, 24, 25, 49, 50, 74, 75, 99, -1, 100};
      logic [7:0] ex [10] = '{0, 24, 56, 32, 64, 88, 120, 96, 0, 96};
      for (int i = 0; i < 10; i++)
      begin
         hm.send(tp[i]);
         #1 check(wiper_code, ex[i]);
         check({7'h0, wiper_update}, 8'h0001);
      end
   endtask : t_map
   initial
   begin
      repeat (6) @(posedge clk);
      resetn <= 1'b1;
      t_recall();
      t_map();
      @(posedge clk) power_good <= 1'b0;
      repeat (2) @(posedge clk);
      #1 check({7'h0, recall_done}, 8'h0000);
      end_sim();
   end
   initial
   begin
      #20000 failures++;
      end_sim();
   end
endmodule : ptpe_tap_encoder_tb_top
bind ptpe_tap_encoder ptpe_asserts chk (.clk(clk), .resetn(resetn), .power_good(power_good),
   .tap_valid(tap_valid), .wiper_update(wiper_update), .recall_done(recall_done),
   .stored_wiper(stored_wiper), .wiper_code(wiper_code), .tap_pos(tap_pos));
`default_nettype wire

// >>> verilog/ptpe_code_if.sv
/*
 Interface carrying a signed tap request to the encoder and the code back.
 Assumes both ends share the one system clock.
*/
`timescale 1ns/1ps
`default_nettype none
interface ptpe_code_if;
   logic signed [7:0] tap;
   logic [7:0]        code;
   modport enc (input tap, output code);
   modport user (output tap, input code);
endinterface : ptpe_code_if
`default_nettype wire

// >>> verilog/ptpe_encoder.sv
/*
 Combinational tap position to wiper byte mapping with range clamp.
 Assumes the tap is a signed two's complement request.
*/
`timescale 1ns/1ps
`default_nettype none
module ptpe_encoder
   import ptpe_pkg::*;
(
   ptpe_code_if.enc port
);
   logic [7:0] t;

   always_comb
   begin
      t = port.tap;
      if (port.tap < 0)
         port.code = CODE_MIN;                       // [R5]
      else if (t > TAP_LAST)
         port.code = CODE_TOP_TAP;                   // [R6]
      else if (t > SEG2_LAST)
         port.code = SEG3_BASE - t;                  // [R4] [R8]
      else if (t > SEG1_LAST)
         port.code = t + SEG2_ADD;                   // [R3] [R8]
      else if (t > SEG0_LAST)
         port.code = SEG1_BASE - t;                  // [R2] [R8]
      else
         port.code = t;                              // [R1] [R8]
   end
endmodule : ptpe_encoder
`default_nettype wire

// >>> verilog/ptpe_pkg.sv
/*
 Constants for the tap position encoder: segment bounds, code offsets,
 clamp codes and the power-up recall delay.
 Assumes a 100 MHz system clock.
*/
package ptpe_pkg;

   // ---------------------------------------------------------------
   // Tap encoding
   // ---------------------------------------------------------------
   localparam int unsigned TAP_W          = 8;
   localparam logic [7:0]  SEG0_LAST      = 8'h18;   // 24
   localparam logic [7:0]  SEG1_LAST      = 8'h31;   // 49
   localparam logic [7:0]  SEG2_LAST      = 8'h4A;   // 74
   localparam logic [7:0]  TAP_LAST       = 8'h63;   // 99
   localparam logic [7:0]  SEG1_BASE      = 8'h51;   // 81
   localparam logic [7:0]  SEG2_ADD       = 8'h0E;   // 14
   localparam logic [7:0]  SEG3_BASE      = 8'hC3;   // 195
   localparam logic [7:0]  CODE_MIN       = 8'h00;
   localparam logic [7:0]  CODE_TOP_TAP   = 8'h60;   // 96
   localparam logic [7:0]  WIPER_RESET    = 8'h00;

   // ---------------------------------------------------------------
   // Power-up recall timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_MHZ        = 100;
   localparam int unsigned RECALL_MIN_MS  = 25;
   localparam int unsigned RECALL_TYP_MS  = 50;
   localparam int unsigned RECALL_MAX_MS  = 75;
   localparam int unsigned RECALL_CYCLES  = RECALL_TYP_MS * 1000 * CLK_MHZ;
   localparam int unsigned RECALL_CNT_W   = 23;

   typedef enum logic [1:0] {
      RCL_IDLE  = 2'b00,
      RCL_WAIT  = 2'b01,
      RCL_DONE  = 2'b10
   } ptpe_recall_type;

endpackage : ptpe_pkg

// >>> verilog/ptpe_tap_encoder.sv
/*
 Tap position encoder for the hundred_tap_potentiometer: maps a requested
 tap to its wiper byte, registers it, and holds the stored setting back
 until the power_up_recall_delay has run out after power-up.
 Assumes power_good rises once the supply passes the
 recall_supply_threshold, and that inputs are synchronous to clk.
*/
// How it works
// R1: Taps 0..24 encode as themselves
// R2: Taps 25..49 encode as 81 minus tap
// R3: Taps 50..74 encode as tap plus 14
// R4: Taps 75..99 encode as 195 minus tap
// R5: Negative tap clamps to code zero
// R6: Tap above 99 clamps to 96
// R7: Stored wiper recalled 50 ms after power-up
// R8: Index 0..99, segments split at 24/49/74
`timescale 1ns/1ps
`default_nettype none
module ptpe_tap_encoder
   import ptpe_pkg::*;
#(
   parameter int unsigned RECALL_CYC = RECALL_CYCLES
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              resetn,
   // Supply monitor
   input  wire logic              power_good,
   input  wire logic [7:0]        stored_wiper,
   // Tap request
   input  wire logic              tap_valid,
   input  wire logic signed [7:0] tap_pos,
   // Wiper output
   output logic [7:0]             wiper_code,
   output logic                   wiper_update,
   output logic                   recall_done
);
   // ---------------------------------------------------------------
   // Encoder
   // ---------------------------------------------------------------
   ptpe_code_if     enc_bus ();
   ptpe_recall_type state_reg;
   logic [RECALL_CNT_W-1:0] cnt_reg;
   logic            ready;

   assign enc_bus.tap = tap_pos;
   assign ready       = (state_reg == RCL_DONE);

   ptpe_encoder u_enc (
      .port (enc_bus)
   );

   // ---------------------------------------------------------------
   // Power-up recall sequencing
   // ---------------------------------------------------------------
   // Supply drop restarts the wait so a brown-out recalls again
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         state_reg <= RCL_IDLE;
         cnt_reg   <= '0;
      end
      else if (!power_good)
      begin
         state_reg <= RCL_IDLE;
         cnt_reg   <= '0;
      end
      else
      begin
         case (state_reg)
            RCL_IDLE:
            begin
               state_reg <= RCL_WAIT;
               cnt_reg   <= '0;
            end
            RCL_WAIT:
            begin
               if (cnt_reg == RECALL_CNT_W'(RECALL_CYC - 1))
                  state_reg <= RCL_DONE;                 // [R7]
               else
                  cnt_reg <= cnt_reg + 1'b1;
            end
            RCL_DONE:
               state_reg <= RCL_DONE;
            default:
               state_reg <= RCL_IDLE;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // Wiper register
   // ---------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!resetn)
      begin
         wiper_code   <= WIPER_RESET;
         wiper_update <= 1'b0;
      end
      else if (power_good && state_reg == RCL_WAIT && cnt_reg == RECALL_CNT_W'(RECALL_CYC - 1))
      begin
         wiper_code   <= stored_wiper;                   // [R7]
         wiper_update <= 1'b1;
      end
      else if (ready && tap_valid)
      begin
         wiper_code   <= enc_bus.code;
         wiper_update <= 1'b1;
      end
      else
         wiper_update <= 1'b0;
   end

   // Requests before recall are dropped: recall must not be overwritten
   assign recall_done = ready;

endmodule : ptpe_tap_encoder
`default_nettype wire
